// >>> verilog/host_memory_port.sv
// Parallel host port: memory window, address pointer and two-way mailbox.
//
// Contract
// - 16-bit multiplexed port to port registers.
// - Address 00 data, 10 address, 01 mailbox.
// - Load pointer, then data accesses use it.
// - Pointer advances after each data access.
// - Whole on-chip memory reachable read and write.
// - Host mailbox write interrupts on-chip processor.
// - Outbound write raises irq; host read clears.
// - Host accesses resynchronised before memory use.
// - Memory access only after winning arbitration.
// - Port beats every other memory requester.
// - At most one word per 25 internal cycles.
// - Prefetch on address load and each data read.
// - Processor reading inbound word clears interrupt.
// - Inbound interrupt gated by enable bit 6.
`timescale 1ns/1ps
`default_nettype none
module host_memory_port
    import host_port_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    // External processor pins.
    input  wire logic [1:0]  host_addr,
    input  wire logic [15:0] host_data_in,
    output var  logic [15:0] host_data_out_ff,
    output var  logic        host_data_oe_ff,
    input  wire logic        host_write_n,
    input  wire logic        host_read_n,
    output var  logic        outbound_mail_irq_ff,
    // On-chip processor memory requester.
    input  wire logic        cpu_mem_req,
    input  wire logic        cpu_mem_we,
    input  wire logic [15:0] cpu_mem_addr,
    input  wire logic [15:0] cpu_mem_wdata,
    output var  logic        cpu_mem_ack_ff,
    output var  logic [15:0] cpu_mem_rdata,
    // On-chip processor mailbox and interrupt enable.
    input  wire logic        cpu_outbox_we,
    input  wire logic [15:0] cpu_outbox_wdata,
    input  wire logic        cpu_inbox_re,
    output var  logic [15:0] inbound_mail_word_ff,
    input  wire logic        cpu_int_enable_we,
    input  wire logic [15:0] cpu_int_enable_wdata,
    output var  logic [15:0] int_enable_ff,
    output var  logic        inbound_mail_irq_ff
);

    // ==========================================================
    // Pin synchronisers: strobes, address and data pass two flops.
    logic        wr_s1_ff, wr_s2_ff, wr_s3_ff;
    logic        rd_s1_ff, rd_s2_ff, rd_s3_ff;
    logic [1:0]  addr_s1_ff, addr_s2_ff;
    logic [15:0] data_s1_ff, data_s2_ff;

    // The third strobe stage only feeds edge detection, never stage one.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_s1_ff   <= 1'b1;
            wr_s2_ff   <= 1'b1;
            wr_s3_ff   <= 1'b1;
            rd_s1_ff   <= 1'b1;
            rd_s2_ff   <= 1'b1;
            rd_s3_ff   <= 1'b1;
            addr_s1_ff <= 2'h0;
            addr_s2_ff <= 2'h0;
            data_s1_ff <= WORD_RESET;
            data_s2_ff <= WORD_RESET;
        end else begin
            wr_s1_ff   <= host_write_n;
            wr_s2_ff   <= wr_s1_ff;
            wr_s3_ff   <= wr_s2_ff;
            rd_s1_ff   <= host_read_n;
            rd_s2_ff   <= rd_s1_ff;
            rd_s3_ff   <= rd_s2_ff;
            addr_s1_ff <= host_addr;
            addr_s2_ff <= addr_s1_ff;
            data_s1_ff <= host_data_in;
            data_s2_ff <= data_s1_ff;
        end
    end

    // A write takes effect at its trailing edge, when the data are settled.
    logic host_wr_done;
    logic host_rd_start;
    logic host_rd_done;
    assign host_wr_done  = wr_s2_ff && !wr_s3_ff;
    assign host_rd_start = !rd_s2_ff && rd_s3_ff;
    assign host_rd_done  = rd_s2_ff && !rd_s3_ff;

    // ==========================================================
    // Port state.
    logic [15:0] ptr_ff, nxt_ptr;
    logic [15:0] prefetch_ff, nxt_prefetch;
    logic [15:0] wr_addr_ff, nxt_wr_addr;
    logic [15:0] wr_data_ff, nxt_wr_data;
    port_op_e    op_ff, nxt_op;
    logic        rd_wait_ff, nxt_rd_wait;
    logic [PACE_W-1:0] pace_ff, nxt_pace;
    logic [15:0] outbound_word_ff, nxt_outbound_word;
    logic [15:0] nxt_inbound_word;
    logic [15:0] nxt_int_enable;
    logic        inbound_pend_ff, nxt_inbound_pend;
    logic        nxt_inbound_irq;
    logic        nxt_outbound_irq;
    logic [15:0] nxt_host_data_out;
    logic        nxt_host_data_oe;
    logic        nxt_cpu_ack;

    // Memory port signals.
    logic              port_go;
    logic              cpu_go;
    logic              mem_en;
    logic              mem_we;
    logic [ADDR_W-1:0] mem_addr;
    logic [15:0]       mem_wdata;
    logic [15:0]       mem_rdata;

    // ==========================================================
    // Arbitration: the port always wins; the processor waits.
    // A pending port operation is started only when pacing allows it.
    assign port_go = (op_ff != OP_NONE) && (pace_ff == PACE_ZERO);
    assign cpu_go  = cpu_mem_req && !port_go && !cpu_mem_ack_ff;

    // Memory mux; only the low address bits reach the array.
    always_comb begin
        mem_en    = port_go || cpu_go;
        mem_we    = 1'b0;
        mem_addr  = ADDR_W'(cpu_mem_addr);
        mem_wdata = cpu_mem_wdata;
        if (port_go) begin
            mem_we    = (op_ff == OP_WRITE);
            mem_addr  = (op_ff == OP_WRITE) ? ADDR_W'(wr_addr_ff) : ADDR_W'(ptr_ff);
            mem_wdata = wr_data_ff;
        end else if (cpu_go) begin
            mem_we = cpu_mem_we;
        end
    end

    port_memory #(
        .ADDR_W (ADDR_W),
        .DATA_W (WORD_W)
    ) u_mem (
        .sys_clk      (sys_clk),
        .mem_en       (mem_en),
        .mem_we       (mem_we),
        .mem_addr     (mem_addr),
        .mem_wdata    (mem_wdata),
        .mem_rdata_ff (mem_rdata)
    );

    assign cpu_mem_rdata = mem_rdata;

    // ==========================================================
    // Next-state logic for pointer, operations, mailboxes and pins.
    always_comb begin
        nxt_ptr           = ptr_ff;
        nxt_prefetch      = prefetch_ff;
        nxt_wr_addr       = wr_addr_ff;
        nxt_wr_data       = wr_data_ff;
        nxt_op            = op_ff;
        nxt_rd_wait       = 1'b0;
        nxt_pace          = pace_ff;
        nxt_outbound_word = outbound_word_ff;
        nxt_inbound_word  = inbound_mail_word_ff;
        nxt_int_enable    = int_enable_ff;
        nxt_inbound_pend  = inbound_pend_ff;
        nxt_outbound_irq  = outbound_mail_irq_ff;
        nxt_host_data_out = host_data_out_ff;
        nxt_host_data_oe  = host_data_oe_ff;
        nxt_cpu_ack       = cpu_go;

        // Pacing counter restarts at each port memory access.
        if (port_go) begin
            nxt_pace = PACE_RELOAD;
            nxt_op   = OP_NONE;
            nxt_rd_wait = (op_ff == OP_PREFETCH);
        end else if (pace_ff != PACE_ZERO) begin
            nxt_pace = pace_ff - 5'h01;
        end

        // Prefetched word lands one cycle after the read was issued.
        if (rd_wait_ff) begin
            nxt_prefetch = mem_rdata;
        end

        // Host read: drive the selected register for the whole strobe.
        if (host_rd_start) begin
            nxt_host_data_oe = 1'b1;
            if (addr_s2_ff == SEL_DATA) begin
                nxt_host_data_out = prefetch_ff;
            end else if (addr_s2_ff == SEL_MAILBOX) begin
                nxt_host_data_out = outbound_word_ff;
            end else if (addr_s2_ff == SEL_ADDRESS) begin
                nxt_host_data_out = ptr_ff;
            end else begin
                nxt_host_data_out = WORD_RESET;
            end
        end

        // Side effects of a read happen as the strobe ends.
        if (host_rd_done) begin
            nxt_host_data_oe = 1'b0;
            if (addr_s2_ff == SEL_DATA) begin
                nxt_ptr = ptr_ff + PTR_STEP;
                nxt_op  = OP_PREFETCH;
            end else if (addr_s2_ff == SEL_MAILBOX) begin
                nxt_outbound_irq = 1'b0;
            end
        end

        // Host write: the address load starts a prefetch, data go to memory.
        if (host_wr_done) begin
            if (addr_s2_ff == SEL_ADDRESS) begin
                nxt_ptr = data_s2_ff;
                nxt_op  = OP_PREFETCH;
            end else if (addr_s2_ff == SEL_DATA) begin
                nxt_wr_addr = ptr_ff;
                nxt_wr_data = data_s2_ff;
                nxt_op      = OP_WRITE;
                nxt_ptr     = ptr_ff + PTR_STEP;
            end else if (addr_s2_ff == SEL_MAILBOX) begin
                nxt_inbound_word = data_s2_ff;
                nxt_inbound_pend = 1'b1;
            end
        end

        // Processor read clears the inbound flag unless a new word arrives now.
        if (cpu_inbox_re && !(host_wr_done && addr_s2_ff == SEL_MAILBOX)) begin
            nxt_inbound_pend = 1'b0;
        end

        // A new outbound word wins over a host read ending in the same cycle.
        if (cpu_outbox_we) begin
            nxt_outbound_word = cpu_outbox_wdata;
            nxt_outbound_irq  = 1'b1;
        end

        if (cpu_int_enable_we) begin
            nxt_int_enable = cpu_int_enable_wdata;
        end
        nxt_inbound_irq = nxt_inbound_pend && nxt_int_enable[INT_EN_MAIL_BIT];
    end

    // ==========================================================
    // State registers.
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_ff               <= WORD_RESET;
            prefetch_ff          <= WORD_RESET;
            wr_addr_ff           <= WORD_RESET;
            wr_data_ff           <= WORD_RESET;
            op_ff                <= OP_NONE;
            rd_wait_ff           <= 1'b0;
            pace_ff              <= PACE_ZERO;
            outbound_word_ff     <= WORD_RESET;
            inbound_mail_word_ff <= WORD_RESET;
            int_enable_ff        <= INT_EN_RESET;
            inbound_pend_ff      <= 1'b0;
            inbound_mail_irq_ff  <= 1'b0;
            outbound_mail_irq_ff <= 1'b0;
            host_data_out_ff     <= WORD_RESET;
            host_data_oe_ff      <= 1'b0;
            cpu_mem_ack_ff       <= 1'b0;
        end else begin
            ptr_ff               <= nxt_ptr;
            prefetch_ff          <= nxt_prefetch;
            wr_addr_ff           <= nxt_wr_addr;
            wr_data_ff           <= nxt_wr_data;
            op_ff                <= nxt_op;
            rd_wait_ff           <= nxt_rd_wait;
            pace_ff              <= nxt_pace;
            outbound_word_ff     <= nxt_outbound_word;
            inbound_mail_word_ff <= nxt_inbound_word;
            int_enable_ff        <= nxt_int_enable;
            inbound_pend_ff      <= nxt_inbound_pend;
            inbound_mail_irq_ff  <= nxt_inbound_irq;
            outbound_mail_irq_ff <= nxt_outbound_irq;
            host_data_out_ff     <= nxt_host_data_out;
            host_data_oe_ff      <= nxt_host_data_oe;
            cpu_mem_ack_ff       <= nxt_cpu_ack;
        end
    end

endmodule
`default_nettype wire

// >>> verilog/host_port_pkg.sv
// Constants shared by the host memory and mailbox port.
`default_nettype none
package host_port_pkg;

    // ==========================================================
    // Port register select codes on the two address pins.
    localparam logic [1:0] SEL_DATA    = 2'h0;
    localparam logic [1:0] SEL_MAILBOX = 2'h1;
    localparam logic [1:0] SEL_ADDRESS = 2'h2;

    // ==========================================================
    // Widths and reset values.
    localparam int         WORD_W        = 16;
    localparam logic [15:0] WORD_RESET   = 16'h0000;
    localparam logic [15:0] PTR_STEP     = 16'h0001;
    localparam int         INT_EN_MAIL_BIT = 6;
    localparam logic [15:0] INT_EN_RESET = 16'h0000;

    // ==========================================================
    // Pacing: one word per 25 cycles of the 200 MHz internal clock.
    localparam int WORD_TIME_PS  = 125000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PACE_CYCLES   = (WORD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int PACE_W        = 5;
    localparam logic [PACE_W-1:0] PACE_RELOAD = PACE_W'(PACE_CYCLES - 1);
    localparam logic [PACE_W-1:0] PACE_ZERO   = 5'h00;

    // Pending memory operation requested by the external processor.
    typedef enum logic [1:0] {
        OP_NONE,
        OP_PREFETCH,
        OP_WRITE
    } port_op_e;

endpackage
`default_nettype wire

// >>> verilog/port_memory.sv
// Single-port on-chip memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module port_memory #(
    parameter int ADDR_W = 10,
    parameter int DATA_W = 16
) (
    input  wire logic              sys_clk,
    input  wire logic              mem_en,
    input  wire logic              mem_we,
    input  wire logic [ADDR_W-1:0] mem_addr,
    input  wire logic [DATA_W-1:0] mem_wdata,
    output var  logic [DATA_W-1:0] mem_rdata_ff
);

    logic [DATA_W-1:0] store [2**ADDR_W];

    // ==========================================================
    // No-change on write, read data registered; no reset so it maps to RAM.
    always_ff @(posedge sys_clk) begin
        if (mem_en && mem_we) begin
            store[mem_addr] <= mem_wdata;
        end
        if (mem_en && !mem_we) begin
            mem_rdata_ff <= store[mem_addr];
        end
    end

endmodule
`default_nettype wire

// >>> sim/host_port_asserts.sv
// Concurrent checks on the host memory and mailbox port.
`timescale 1ns/1ps
`default_nettype none
module host_port_asserts
    import host_port_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic [1:0]  host_addr,
    input wire logic        host_read_n,
    input wire logic        host_write_n,
    input wire logic        host_data_oe_ff,
    input wire logic        outbound_mail_irq_ff,
    input wire logic        cpu_mem_req,
    input wire logic        cpu_mem_ack_ff,
    input wire logic        cpu_outbox_we,
    input wire logic        cpu_inbox_re,
    input wire logic [15:0] int_enable_ff,
    input wire logic        inbound_mail_irq_ff
);
    // ========================================
    // Properties. Strobe pins pass two sync flops, so their windows allow a little slack.
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    a_read_drives: assert property (
        $fell(host_read_n) |-> ##[2:5] host_data_oe_ff)
        else $error("Read data not driven after strobe fell.");
    a_drive_ends: assert property (
        host_read_n [*6] |-> !host_data_oe_ff)
        else $error("Data bus still driven with no read.");
    a_outirq_raise: assert property (
        cpu_outbox_we |=> outbound_mail_irq_ff)
        else $error("Outbound interrupt not raised.");
    a_outirq_clear: assert property (
        $rose(host_read_n) && host_addr == SEL_MAILBOX && !cpu_outbox_we
        |-> ##[2:6] !outbound_mail_irq_ff)
        else $error("Outbound interrupt not cleared by host read.");
    a_inirq_gate: assert property (
        !int_enable_ff[INT_EN_MAIL_BIT] && !$past(int_enable_ff[INT_EN_MAIL_BIT])
        |-> !inbound_mail_irq_ff)
        else $error("Inbound interrupt passed while disabled.");
    a_inirq_clear: assert property (
        host_write_n [*5] ##0 cpu_inbox_re |-> ##2 !inbound_mail_irq_ff)
        else $error("Inbound interrupt not cleared by processor read.");
    a_ack_bounded: assert property (
        cpu_mem_req && !cpu_mem_ack_ff |-> ##[1:30] cpu_mem_ack_ff)
        else $error("Processor memory request never acknowledged.");
    a_ack_pulse: assert property (
        cpu_mem_ack_ff |=> !cpu_mem_ack_ff)
        else $error("Acknowledge longer than one cycle.");
    c_outbound: cover property (cpu_outbox_we ##1 outbound_mail_irq_ff);
    c_inbound: cover property ($rose(inbound_mail_irq_ff));
    c_cpu_ack: cover property (cpu_mem_ack_ff);
    // A processor request that the port's own memory cycle pushes back by one clock.
    c_cpu_delayed: cover property ((cpu_mem_req && !cpu_mem_ack_ff) ##1
        (cpu_mem_req && !cpu_mem_ack_ff));
endmodule
`default_nettype wire

// >>> sim/host_model.sv
// Behavioural external host processor on the parallel port pins.
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic        sys_clk,
    output var  logic [1:0]  host_addr,
    output var  logic [15:0] host_data_in,
    output var  logic        host_write_n,
    output var  logic        host_read_n,
    input  wire logic [15:0] host_data_out_ff,
    input  wire logic        host_data_oe_ff
);
    // ========================================
    // Bus cycles. Long strobes and wide gaps, because every pin is resynchronised
    // and a data word sent too soon would overwrite the one still pending.
    initial begin
        host_addr = 2'h3;
        host_data_in = 16'h0000;
        host_write_n = 1'b1;
        host_read_n = 1'b1;
    end
    task automatic host_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        host_addr <= a;
        host_data_in <= d;
        repeat (4) @(posedge sys_clk);
        host_write_n <= 1'b0;
        repeat (6) @(posedge sys_clk);
        host_write_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        host_data_in <= ~d; // A released bus must not keep showing the old word.
        repeat (26) @(posedge sys_clk);
    endtask
    task automatic host_rd(input logic [1:0] a, output logic [15:0] d, output logic oe);
        @(posedge sys_clk);
        host_addr <= a;
        repeat (4) @(posedge sys_clk);
        host_read_n <= 1'b0;
        repeat (7) @(posedge sys_clk);
        d = host_data_out_ff;
        oe = host_data_oe_ff;
        host_read_n <= 1'b1;
        repeat (30) @(posedge sys_clk);
    endtask
endmodule
`default_nettype wire

// >>> sim/host_memory_port_tb_top.sv
// Self-checking bench for the host memory and mailbox port.
`timescale 1ns/1ps
`default_nettype none
module host_memory_port_tb_top
    import host_port_pkg::*;
;
    logic        sys_clk, reset_n, host_data_oe_ff, host_write_n, host_read_n, rd_oe;
    logic        outbound_mail_irq_ff, cpu_mem_req, cpu_mem_we, cpu_mem_ack_ff;
    logic        cpu_outbox_we, cpu_inbox_re, cpu_int_enable_we, inbound_mail_irq_ff;
    logic [1:0]  host_addr;
    logic [15:0] host_data_in, host_data_out_ff, cpu_mem_addr, cpu_mem_wdata, cpu_mem_rdata;
    logic [15:0] cpu_outbox_wdata, inbound_mail_word_ff, cpu_int_enable_wdata, int_enable_ff;
    logic [15:0] rd_word;
    int          num_errors, n_compared;
    // ========================================
    // Design, host model and clock.
    host_memory_port #(.ADDR_W(10)) i_host_memory_port (.sys_clk, .reset_n, .host_addr,
        .host_data_in, .host_data_out_ff, .host_data_oe_ff, .host_write_n, .host_read_n,
        .outbound_mail_irq_ff, .cpu_mem_req, .cpu_mem_we, .cpu_mem_addr, .cpu_mem_wdata,
        .cpu_mem_ack_ff, .cpu_mem_rdata, .cpu_outbox_we, .cpu_outbox_wdata, .cpu_inbox_re,
        .inbound_mail_word_ff, .cpu_int_enable_we, .cpu_int_enable_wdata, .int_enable_ff,
        .inbound_mail_irq_ff);
    host_model i_host_model (.sys_clk, .host_addr, .host_data_in, .host_write_n,
        .host_read_n, .host_data_out_ff, .host_data_oe_ff);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ========================================
    // Shared tasks.
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cpu_mem(input logic we, input logic [15:0] a, input logic [15:0] d);
        int n;
        @(posedge sys_clk);
        {cpu_mem_req, cpu_mem_we, cpu_mem_addr, cpu_mem_wdata} <= {1'b1, we, a, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (cpu_mem_ack_ff !== 1'b1 && n < 50);
        check({15'h0000, cpu_mem_ack_ff}, 16'h0001);
        cpu_mem_req <= 1'b0;
    endtask
    // One-cycle processor strobe: 0 outbox write, 1 inbox read, 2 enable write.
    task automatic cpu_strobe(input logic [1:0] kind, input logic [15:0] d);
        @(posedge sys_clk);
        {cpu_outbox_we, cpu_inbox_re, cpu_int_enable_we} <= {kind == 0, kind == 1, kind == 2};
        {cpu_outbox_wdata, cpu_int_enable_wdata} <= {d, d};
        @(posedge sys_clk);
        {cpu_outbox_we, cpu_inbox_re, cpu_int_enable_we} <= 3'h0;
    endtask
    // ========================================
    // Scenarios.
    task automatic t_block_transfer();
        i_host_model.host_wr(SEL_ADDRESS, 16'h0010);
        for (int i = 0; i < 4; i++) i_host_model.host_wr(SEL_DATA, 16'hA5A0 + 16'(i));
        i_host_model.host_wr(SEL_ADDRESS, 16'h0010);
        for (int i = 0; i < 4; i++) begin
            i_host_model.host_rd(SEL_DATA, rd_word, rd_oe);
            check(rd_word, 16'hA5A0 + 16'(i));
            check({15'h0000, rd_oe}, 16'h0001);
        end
        // Four reads from 0x0010 leave the pointer at 0x0014.
        i_host_model.host_rd(SEL_ADDRESS, rd_word, rd_oe);
        check(rd_word, 16'h0014);
        cpu_mem(1'b0, 16'h0012, 16'h0000);
        check(cpu_mem_rdata, 16'hA5A2);
    endtask
    // Host and processor contend for memory in the same window.
    task automatic t_memory_edges();
        cpu_mem(1'b1, 16'h03FF, 16'h5AC3);
        i_host_model.host_wr(SEL_ADDRESS, 16'h03FF);
        i_host_model.host_rd(SEL_DATA, rd_word, rd_oe);
        check(rd_word, 16'h5AC3);
        i_host_model.host_wr(SEL_ADDRESS, 16'h0000);
        // The request is timed to meet the port's write to the same word; the port
        // goes first, so the processor's word is the one left in memory.
        fork
            i_host_model.host_wr(SEL_DATA, 16'hC33C);
            begin
                repeat (13) @(posedge sys_clk);
                cpu_mem(1'b1, 16'h0000, 16'h7E81);
            end
        join
        cpu_mem(1'b0, 16'h0000, 16'h0000);
        check(cpu_mem_rdata, 16'h7E81);
        i_host_model.host_wr(SEL_ADDRESS, 16'h0000);
        i_host_model.host_rd(SEL_DATA, rd_word, rd_oe);
        check(rd_word, 16'h7E81);
    endtask
    task automatic t_inbound_mail();
        check(int_enable_ff, INT_EN_RESET);
        i_host_model.host_wr(SEL_MAILBOX, 16'h1234);
        check(inbound_mail_word_ff, 16'h1234);
        check({15'h0000, inbound_mail_irq_ff}, 16'h0000);
        cpu_strobe(2'h2, 16'h0040);
        repeat (3) @(posedge sys_clk);
        check(int_enable_ff, 16'h0040);
        check({15'h0000, inbound_mail_irq_ff}, 16'h0001);
        cpu_strobe(2'h1, 16'h0000);
        repeat (3) @(posedge sys_clk);
        check({15'h0000, inbound_mail_irq_ff}, 16'h0000);
    endtask
    task automatic t_outbound_mail();
        cpu_strobe(2'h0, 16'hBEEF);
        cpu_strobe(2'h0, 16'hC0DE);
        @(posedge sys_clk);
        check({15'h0000, outbound_mail_irq_ff}, 16'h0001);
        i_host_model.host_rd(SEL_MAILBOX, rd_word, rd_oe);
        check(rd_word, 16'hC0DE);
        check({15'h0000, outbound_mail_irq_ff}, 16'h0000);
    endtask
    task automatic complete_run();
        $display("Compared %0d, mismatched %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ========================================
    // Main sequence; the whole run needs under 2000 cycles, so the limit is generous.
    initial begin
        num_errors = 0;
        n_compared = 0;
        reset_n = 1'b0;
        {cpu_mem_req, cpu_mem_we, cpu_mem_addr, cpu_mem_wdata} = 34'h0;
        {cpu_outbox_we, cpu_inbox_re, cpu_int_enable_we} = 3'h0;
        {cpu_outbox_wdata, cpu_int_enable_wdata} = 32'h0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        t_inbound_mail();
        t_block_transfer();
        t_memory_edges();
        t_outbound_mail();
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        complete_run();
    end
endmodule
bind host_memory_port host_port_asserts i_host_port_asserts (.sys_clk, .reset_n, .host_addr,
    .host_read_n, .host_write_n, .host_data_oe_ff, .outbound_mail_irq_ff, .cpu_mem_req,
    .cpu_mem_ack_ff, .cpu_outbox_we, .cpu_inbox_re, .int_enable_ff, .inbound_mail_irq_ff);
`default_nettype wire
